/* design/scbm_pkg.sv */
// shared types and constants for the system control and block copy unit
package scbm_pkg;
	// operations the unit executes
	typedef enum logic [2:0] {
		OP_TRAP = 3'h0,
		OP_RTE = 3'h1,
		OP_SLEEP = 3'h2,
		OP_LDC_INC = 3'h3,
		OP_STC_DEC = 3'h4,
		OP_BLK_B = 3'h5,
		OP_BLK_W = 3'h6,
		OP_NONE = 3'h7
	} scbm_op_t;

	// execution lengths in states, on-chip memory, no wait
	localparam logic [19:0] TRAP_NORM_STATES = 20'h0000E;
	localparam logic [19:0] TRAP_ADV_STATES = 20'h00010;
	localparam logic [19:0] RTE_STATES = 20'h0000A;
	localparam logic [19:0] SLEEP_STATES = 20'h00002;
	localparam logic [19:0] LDC_INC_STATES = 20'h00008;
	localparam logic [19:0] STC_DEC_STATES = 20'h00008;
	localparam logic [19:0] BLK_BASE_STATES = 20'h00008;
	localparam logic [19:0] IDLE_OP_STATES = 20'h00002;

	// memory accesses per operation
	localparam logic [2:0] TRAP_ADV_ACCS = 3'h5;
	localparam logic [2:0] TRAP_NORM_ACCS = 3'h3;
	localparam logic [2:0] RTE_ADV_ACCS = 3'h3;
	localparam logic [2:0] RTE_NORM_ACCS = 3'h2;
	localparam logic [2:0] TRAP_ADV_PUSHES = 3'h3;
	localparam logic [2:0] TRAP_NORM_PUSHES = 3'h2;

	// pointer and stack steps
	localparam logic [31:0] PTR_STEP = 32'h00000002;
	localparam logic [23:0] WORD_STEP = 24'h000002;
	localparam logic [31:0] FRAME_ADV = 32'h00000006;
	localparam logic [31:0] FRAME_NORM = 32'h00000004;
	localparam logic [23:0] VEC_BASE_DEF = 24'h000020;
	localparam int FIFO_DEPTH = 8;

	// instruction as handed to the unit
	typedef struct packed {
		scbm_op_t op;
		logic [1:0] imm;
		logic adv;
		logic [23:0] pc;
		logic [31:0] sp;
		logic [7:0] condition_code_register;
		logic [31:0] ptr;
		logic [15:0] cnt;
		logic [15:0] src;
		logic [15:0] dst;
	} scbm_cmd_t;

	// architectural state after the instruction
	typedef struct packed {
		logic [23:0] pc;
		logic [31:0] sp;
		logic [7:0] condition_code_register;
		logic [31:0] ptr;
		logic [15:0] cnt;
		logic [15:0] src;
		logic [15:0] dst;
	} scbm_res_t;

	// one memory access
	typedef struct packed {
		logic we;
		logic byte_en;
		logic [23:0] addr;
		logic [15:0] wdata;
	} scbm_acc_t;
endpackage

/* design/scbm_exec.sv */
// execution unit: trap, exception return, sleep, ccr load/store, block copy
// Functional notes
// - trap pushes pc then ccr with pre-decrement, loads pc from vector, 14/16 states
// - exception return pops ccr then pc with post-increment, all flags restored
// - sleep enters power-down in 2 states and leaves every flag alone
// - ccr load with post-increment reads a word, adds 2 to the pointer, 8 states
// - ccr store with pre-decrement subtracts 2 first, then writes the word
// - byte block copy with zero count copies nothing and ends
// - word block copy uses the 16-bit count, skipping when it starts at zero
// - each copy step moves a byte, bumps both pointers, decrements the count
// - a block copy takes 8 states plus 4 per byte
// - state counts hold for on-chip memory with no wait states
// - slow or synchronised accesses stretch the execution length
`timescale 1ns/1ps

module scbm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] fill_reg;
	logic push;
	logic pop;

	// honest full and empty from the fill level
	assign in_ready = fill_reg != (AW+1)'(DEPTH);
	assign out_valid = fill_reg != '0;
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage is written only on a push
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	// pointers wrap explicitly, depth need not be a power of two
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			fill_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			fill_reg <= fill_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module scbm_exec
	import scbm_pkg::*;
#(
	parameter logic [23:0] TRAP_VEC_BASE = VEC_BASE_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// instruction command
	input wire logic start,
	input wire scbm_cmd_t cmd,
	output logic busy,
	output logic done,
	output scbm_res_t res,
	// power-down
	output logic sleep_mode,
	input wire logic wake,
	// memory bus
	output logic mem_req,
	output scbm_acc_t mem_acc,
	input wire logic mem_ready,
	input wire logic [15:0] mem_rdata
);
	typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} scbm_state_t;

	scbm_state_t state_reg;
	scbm_cmd_t cmd_reg;
	scbm_res_t res_reg;
	scbm_acc_t mem_acc_reg;
	logic mem_req_reg;
	logic done_reg;
	logic sleep_mode_reg;
	logic [2:0] k_reg;
	logic [2:0] cur_reg;
	logic [2:0] nacc_reg;
	logic [19:0] cyc_reg;
	logic [19:0] target_reg;
	logic [15:0] rd_left_reg;
	logic take, run, xfer, bus_free, is_blk, rd_done;
	logic seq_issue, blk_rd_issue, blk_wr_issue, work_done, finish;
	logic fifo_in_ready, fifo_out_valid;
	logic [7:0] fifo_out;

	// byte count seen by a block copy
	function automatic logic [15:0] n_of(scbm_cmd_t c);
		return (c.op == OP_BLK_W) ? c.cnt : {8'h00, c.cnt[7:0]};
	endfunction

	// states an instruction occupies when memory never waits
	function automatic logic [19:0] target_of(scbm_cmd_t c);
		case (c.op)
			OP_TRAP: return c.adv ? TRAP_ADV_STATES : TRAP_NORM_STATES;
			OP_RTE: return RTE_STATES;
			OP_SLEEP: return SLEEP_STATES;
			OP_LDC_INC: return LDC_INC_STATES;
			OP_STC_DEC: return STC_DEC_STATES;
			OP_BLK_B, OP_BLK_W: return BLK_BASE_STATES + {2'h0, n_of(c), 2'h0};
			default: return IDLE_OP_STATES;
		endcase
	endfunction

	// word accesses of the non-copy instructions
	function automatic logic [2:0] nacc_of(scbm_cmd_t c);
		case (c.op)
			OP_TRAP: return c.adv ? TRAP_ADV_ACCS : TRAP_NORM_ACCS;
			OP_RTE: return c.adv ? RTE_ADV_ACCS : RTE_NORM_ACCS;
			OP_LDC_INC, OP_STC_DEC: return 3'h1;
			default: return 3'h0;
		endcase
	endfunction

	// k-th access: pushes walk down from sp, pops walk up
	function automatic scbm_acc_t plan_acc(scbm_cmd_t c, logic [2:0] k,
		logic [23:0] vb);
		scbm_acc_t a;
		logic [2:0] nw;
		logic [23:0] vec;
		a = '0;
		nw = c.adv ? TRAP_ADV_PUSHES : TRAP_NORM_PUSHES;
		vec = c.adv ? vb + {20'h0, c.imm, 2'h0} : vb + {21'h0, c.imm, 1'b0};
		case (c.op)
			OP_TRAP:
			begin
				a.we = k < nw;
				if (a.we)
					a.addr = c.sp[23:0] - {20'h0, k + 3'h1, 1'b0};
				else
					a.addr = vec + {20'h0, k - nw, 1'b0};
				if (k == 3'h0)
					a.wdata = c.pc[15:0];
				else if (k == nw - 3'h1)
					a.wdata = {c.condition_code_register, 8'h00};
				else
					a.wdata = {8'h00, c.pc[23:16]};
			end
			OP_RTE: a.addr = c.sp[23:0] + {20'h0, k, 1'b0};
			OP_LDC_INC: a.addr = c.ptr[23:0];
			OP_STC_DEC:
			begin
				a.we = 1'b1;
				a.addr = c.ptr[23:0] - WORD_STEP;
				a.wdata = {c.condition_code_register, 8'h00};
			end
			default: a = '0;
		endcase
		return a;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// sequencing decisions

	assign take = start && (state_reg == ST_IDLE);
	assign run = state_reg == ST_RUN;
	assign xfer = mem_req_reg && mem_ready;
	assign bus_free = !mem_req_reg || mem_ready;
	assign is_blk = (cmd_reg.op == OP_BLK_B) || (cmd_reg.op == OP_BLK_W);
	assign rd_done = xfer && !mem_acc_reg.we;
	assign seq_issue = run && !is_blk && bus_free && (k_reg < nacc_reg);
	// reads fill the fifo first; writes drain it when reads must wait
	assign blk_rd_issue = run && is_blk && bus_free && !rd_done &&
		(rd_left_reg != 16'h0000) && fifo_in_ready;
	assign blk_wr_issue = run && is_blk && bus_free && !rd_done &&
		!blk_rd_issue && fifo_out_valid;
	assign work_done = !mem_req_reg && (k_reg == nacc_reg) &&
		(rd_left_reg == 16'h0000) && !fifo_out_valid;
	// padding to the listed count; waits only lengthen it
	assign finish = run && work_done && (cyc_reg >= target_reg);

	// bytes in flight between source and destination
	scbm_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.in_valid(rd_done && is_blk),
		.in_ready(fifo_in_ready),
		.in_data(mem_rdata[7:0]),
		.out_valid(fifo_out_valid),
		.out_ready(blk_wr_issue),
		.out_data(fifo_out)
	);

	////////////////////////////////////////////////////////////////////////
	// instruction control

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= ST_IDLE;
			cmd_reg <= '0;
			k_reg <= 3'h0;
			cur_reg <= 3'h0;
			nacc_reg <= 3'h0;
			cyc_reg <= 20'h00000;
			target_reg <= 20'h00000;
			rd_left_reg <= 16'h0000;
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= finish;
			if (take)
			begin
				state_reg <= ST_RUN;
				cmd_reg <= cmd;
				k_reg <= 3'h0;
				nacc_reg <= nacc_of(cmd);
				cyc_reg <= 20'h00001;
				target_reg <= target_of(cmd);
				// a zero count leaves nothing to read
				rd_left_reg <= (cmd.op == OP_BLK_B || cmd.op == OP_BLK_W) ?
					n_of(cmd) : 16'h0000;
			end
			else if (run)
			begin
				cyc_reg <= cyc_reg + 20'h00001;
				if (finish)
					state_reg <= ST_IDLE;
				if (seq_issue)
				begin
					k_reg <= k_reg + 3'h1;
					cur_reg <= k_reg;
				end
				if (blk_rd_issue)
					rd_left_reg <= rd_left_reg - 16'h0001;
			end
		end
	end

	// bus access register, held until the memory answers ready
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mem_req_reg <= 1'b0;
			mem_acc_reg <= '0;
		end
		else if (seq_issue)
		begin
			mem_req_reg <= 1'b1;
			mem_acc_reg <= plan_acc(cmd_reg, k_reg, TRAP_VEC_BASE);
		end
		else if (blk_rd_issue || blk_wr_issue)
		begin
			mem_req_reg <= 1'b1;
			mem_acc_reg.we <= blk_wr_issue;
			mem_acc_reg.byte_en <= 1'b1;
			mem_acc_reg.addr <= blk_wr_issue ? {8'h00, res_reg.dst} :
				{8'h00, res_reg.src};
			mem_acc_reg.wdata <= {8'h00, fifo_out};
		end
		else if (mem_ready)
			mem_req_reg <= 1'b0;
	end

	// architectural results, loaded at the take, then updated as accesses issue or resolve
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			res_reg <= '0;
		else if (take)
		begin
			res_reg.pc <= cmd.pc;
			res_reg.condition_code_register <= cmd.condition_code_register;
			res_reg.ptr <= cmd.ptr;
			res_reg.cnt <= cmd.cnt;
			res_reg.src <= cmd.src;
			res_reg.dst <= cmd.dst;
			if (cmd.op == OP_TRAP)
				res_reg.sp <= cmd.sp - (cmd.adv ? FRAME_ADV : FRAME_NORM);
			else if (cmd.op == OP_RTE)
				res_reg.sp <= cmd.sp + (cmd.adv ? FRAME_ADV : FRAME_NORM);
			else
				res_reg.sp <= cmd.sp;
		end
		else if (run)
		begin
			if (rd_done && cmd_reg.op == OP_TRAP)
			begin
				if (cmd_reg.adv && cur_reg == TRAP_ADV_PUSHES)
					res_reg.pc[23:16] <= mem_rdata[7:0];
				else
					res_reg.pc[15:0] <= mem_rdata;
			end
			if (rd_done && cmd_reg.op == OP_RTE)
			begin
				if (cur_reg == 3'h0)
					res_reg.condition_code_register <= mem_rdata[15:8];
				else if (cmd_reg.adv && cur_reg == 3'h1)
					res_reg.pc[23:16] <= mem_rdata[7:0];
				else
					res_reg.pc[15:0] <= mem_rdata;
			end
			if (rd_done && cmd_reg.op == OP_LDC_INC)
			begin
				res_reg.condition_code_register <= mem_rdata[15:8];
				res_reg.ptr <= res_reg.ptr + PTR_STEP;
			end
			if (seq_issue && cmd_reg.op == OP_STC_DEC)
				res_reg.ptr <= res_reg.ptr - PTR_STEP;
			if (blk_rd_issue)
				res_reg.src <= res_reg.src + 16'h0001;
			if (blk_wr_issue)
			begin
				res_reg.dst <= res_reg.dst + 16'h0001;
				if (cmd_reg.op == OP_BLK_W)
					res_reg.cnt <= res_reg.cnt - 16'h0001;
				else
					res_reg.cnt[7:0] <= res_reg.cnt[7:0] - 8'h01;
			end
		end
	end

	// power-down flag; a sleep ending with a wake still wins
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			sleep_mode_reg <= 1'b0;
		else if (finish && cmd_reg.op == OP_SLEEP)
			sleep_mode_reg <= 1'b1;
		else if (wake)
			sleep_mode_reg <= 1'b0;
	end

	assign busy = state_reg == ST_RUN;
	assign done = done_reg;
	assign res = res_reg;
	assign sleep_mode = sleep_mode_reg;
	assign mem_req = mem_req_reg;
	assign mem_acc = mem_acc_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	logic [19:0] hlp_len_reg;
	logic hlp_stall_reg;

	// busy length and whether memory ever waited
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			hlp_len_reg <= 20'h00000;
			hlp_stall_reg <= 1'b0;
		end
		else if (take)
		begin
			hlp_len_reg <= 20'h00000;
			hlp_stall_reg <= 1'b0;
		end
		else if (run)
		begin
			hlp_len_reg <= hlp_len_reg + 20'h00001;
			if (mem_req_reg && !mem_ready)
				hlp_stall_reg <= 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_trap_adv;
		take && cmd.op == OP_TRAP && cmd.adv;
	endsequence
	sequence s_wait16;
		##[1:16] (mem_req_reg && !mem_ready);
	endsequence

	chk_trap_adv_len: assert property (
		s_trap_adv |-> (##17 done_reg) or s_wait16)
		else $error("advanced trap length wrong");
	chk_trap_vec_sel: assert property (
		mem_req_reg && !mem_acc_reg.we && cmd_reg.op == OP_TRAP &&
		!cmd_reg.adv |-> mem_acc_reg.addr ==
		TRAP_VEC_BASE + {21'h0, cmd_reg.imm, 1'b0})
		else $error("trap vector address wrong");
	chk_rte_ccr_pop: assert property (
		rd_done && cmd_reg.op == OP_RTE && cur_reg == 3'h0 |=>
		($past(mem_rdata) & 16'hFF00) == {res_reg.condition_code_register, 8'h00})
		else $error("restored flags wrong");
	chk_sleep_flags: assert property (
		take && cmd.op == OP_SLEEP |-> ##3 (done_reg && sleep_mode_reg &&
		res_reg.condition_code_register == $past(cmd.condition_code_register, 3)))
		else $error("sleep timing or flags wrong");
	chk_ldc_post_inc: assert property (
		take && cmd.op == OP_LDC_INC |-> (##9 (done_reg &&
		res_reg.ptr == cmd_reg.ptr + PTR_STEP)) or
		(##[1:8] (mem_req_reg && !mem_ready)))
		else $error("ccr load pointer or length wrong");
	chk_stc_pre_dec: assert property (
		mem_req_reg && cmd_reg.op == OP_STC_DEC |-> mem_acc_reg.we &&
		mem_acc_reg.addr == cmd_reg.ptr[23:0] - WORD_STEP &&
		res_reg.ptr == cmd_reg.ptr - PTR_STEP &&
		mem_acc_reg.wdata[15:8] == cmd_reg.condition_code_register)
		else $error("ccr store pre-decrement wrong");
	chk_blk_zero_byte: assert property (
		take && cmd.op == OP_BLK_B && cmd.cnt[7:0] == 8'h00 |->
		##1 (!mem_req_reg)[*8] ##1 done_reg)
		else $error("zero byte count still copied");
	chk_blk_zero_word: assert property (
		take && cmd.op == OP_BLK_W && cmd.cnt == 16'h0000 |->
		##1 (!mem_req_reg)[*8] ##1 done_reg)
		else $error("zero word count still copied");
	chk_blk_pointers: assert property (
		done_reg && is_blk |-> res_reg.src - cmd_reg.src == n_of(cmd_reg) &&
		res_reg.dst - cmd_reg.dst == n_of(cmd_reg) &&
		(cmd_reg.op == OP_BLK_W ? res_reg.cnt : {8'h00, res_reg.cnt[7:0]}) ==
		16'h0000)
		else $error("block copy pointers or count wrong");
	chk_blk_length: assert property (
		done_reg && is_blk && !hlp_stall_reg |-> hlp_len_reg ==
		BLK_BASE_STATES + {2'h0, n_of(cmd_reg), 2'h0})
		else $error("block copy length wrong");
	chk_len_exact: assert property (
		done_reg && !hlp_stall_reg |-> hlp_len_reg == target_reg)
		else $error("state count wrong without waits");
	chk_len_stretch: assert property (
		done_reg && hlp_stall_reg |-> hlp_len_reg >= target_reg)
		else $error("waited instruction ended too early");
endmodule

/* verification/scbm_mem_model.sv */
// on-chip memory partner on the cpu bus, with optional wait states
`timescale 1ns/1ps

module scbm_mem_model
	import scbm_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// access from the unit
	input wire logic mem_req,
	input wire scbm_acc_t mem_acc,
	output logic mem_ready,
	output logic [15:0] mem_rdata,
	// wait states per access, set by the bench
	input wire logic [3:0] waits
);
	logic [7:0] mem [0:1023];
	logic [3:0] wcnt = 4'h0;
	logic [15:0] last = 16'h0000;
	logic [9:0] a;

	////////////////////////////////////////////////////////////////////////
	// zero waits gives the listed counts, waits beyond the padding slack stretch the op
	assign mem_ready = mem_req && (wcnt >= waits);
	assign a = mem_acc.addr[9:0];

	// read data only in the completing cycle, else never the old value
	always_comb
	begin
		if (mem_ready && !mem_acc.we)
			mem_rdata = mem_acc.byte_en ? {8'h00, mem[a]} :
				{mem[a], mem[a + 10'h001]};
		else
			mem_rdata = ~last;
	end

	////////////////////////////////////////////////////////////////////////
	// store, wait count; plain always so the bench may preload the array
	always @(posedge sys_clk)
	begin
		if (mem_req && mem_ready)
		begin
			wcnt <= 4'h0;
			last <= mem_rdata;
			if (mem_acc.we && mem_acc.byte_en)
				mem[a] <= mem_acc.wdata[7:0];
			else if (mem_acc.we)
			begin
				mem[a] <= mem_acc.wdata[15:8];
				mem[a + 10'h001] <= mem_acc.wdata[7:0];
			end
		end
		else if (mem_req)
			wcnt <= wcnt + 4'h1;
	end
endmodule

/* verification/system_control_block_move_exec_tb.sv */
// self-checking bench for the system control and block copy unit
`timescale 1ns/1ps

module system_control_block_move_exec_tb
	import scbm_pkg::*;
;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic start = 1'b0;
	scbm_cmd_t cmd = '0;
	logic busy, done, sleep_mode, mem_req, mem_ready;
	logic wake = 1'b0;
	scbm_res_t res;
	scbm_acc_t mem_acc;
	logic [15:0] mem_rdata;
	logic [3:0] waits = 4'h0;
	int failures = 0;
	int n_checks = 0;

	////////////////////////////////////////////////////////////////////////
	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;

	scbm_exec i_scbm_exec (.sys_clk(sys_clk), .resetn(resetn),
		.start(start), .cmd(cmd), .busy(busy), .done(done), .res(res),
		.sleep_mode(sleep_mode), .wake(wake), .mem_req(mem_req),
		.mem_acc(mem_acc), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
	scbm_mem_model i_scbm_mem_model (.sys_clk(sys_clk), .mem_req(mem_req),
		.mem_acc(mem_acc), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
		.waits(waits));

	////////////////////////////////////////////////////////////////////////
	// verdict and end of run, reached from the main sequence, the run timeout or the hang guard
	task automatic complete_run();
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// big-endian word access to the partner's array
	task automatic setw(input logic [9:0] a, input logic [15:0] v);
		i_scbm_mem_model.mem[a] = v[15:8];
		i_scbm_mem_model.mem[a + 10'h001] = v[7:0];
	endtask

	function automatic logic [15:0] getw(input logic [9:0] a);
		return {i_scbm_mem_model.mem[a], i_scbm_mem_model.mem[a + 10'h001]};
	endfunction

	function automatic logic [7:0] getb(input logic [9:0] a);
		return i_scbm_mem_model.mem[a];
	endfunction

	function automatic scbm_cmd_t mk(input scbm_op_t op);
		scbm_cmd_t c;
		c = '0;
		c.op = op;
		c.sp = 32'h00000200;
		c.condition_code_register = 8'hA5;
		c.ptr = 32'h00000100;
		c.src = 16'h0300;
		c.dst = 16'h0340;
		return c;
	endfunction

	// issue at a falling edge, count cycles up to the done pulse;
	// returns in the done cycle so the next op can follow back to back
	task automatic run(input scbm_cmd_t c, output int n);
		start = 1'b1;
		cmd = c;
		@(negedge sys_clk);
		start = 1'b0;
		chk(busy, 1'b1);
		n = 1;
		while (done !== 1'b1 && n < 300)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 300)
		begin
			failures++;
			complete_run();
		end
		chk(busy, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// traps in both modes, two different vector entries
	task automatic t_trap();
		scbm_cmd_t c;
		int n;
		c = mk(OP_TRAP);
		c.imm = 2'h2;
		c.pc = 24'h001234;
		setw(10'h024, 16'h0456);
		run(c, n);
		chk(n, 32'h0F);
		chk(res.pc[15:0], 16'h0456);
		chk(res.sp, 32'h1FC);
		chk(getw(10'h1FE), 16'h1234);
		chk(getw(10'h1FC), 16'hA500);
		c.adv = 1'b1;
		c.imm = 2'h3;
		c.pc = 24'h056789;
		setw(10'h02C, 16'h0007);
		setw(10'h02E, 16'hABCD);
		run(c, n);
		chk(n, 32'h11);
		chk(res.pc, 24'h07ABCD);
		chk(res.sp, 32'h1FA);
		chk(getw(10'h1FE), 16'h6789);
		chk(getw(10'h1FC), 16'h0005);
		chk(getw(10'h1FA), 16'hA500);
	endtask

	// exception return restores all flags and the pc
	task automatic t_rte();
		scbm_cmd_t c;
		int n;
		c = mk(OP_RTE);
		c.condition_code_register = 8'h00;
		setw(10'h200, 16'h3C00);
		setw(10'h202, 16'h4321);
		run(c, n);
		chk(n, 32'h0B);
		chk(res.condition_code_register, 8'h3C);
		chk(res.pc[15:0], 16'h4321);
		chk(res.sp, 32'h204);
		c.adv = 1'b1;
		setw(10'h200, 16'hC300);
		setw(10'h202, 16'h0012);
		setw(10'h204, 16'h3456);
		run(c, n);
		chk(n, 32'h0B);
		chk(res.condition_code_register, 8'hC3);
		chk(res.pc, 24'h123456);
		chk(res.sp, 32'h206);
	endtask

	// power-down entry keeps the flags; wake leaves it
	task automatic t_sleep();
		scbm_cmd_t c;
		int n;
		c = mk(OP_SLEEP);
		run(c, n);
		chk(n, 32'h03);
		chk(sleep_mode, 1'b1);
		chk(res.condition_code_register, 8'hA5);
		wake = 1'b1;
		@(negedge sys_clk);
		wake = 1'b0;
		chk(sleep_mode, 1'b0);
		// wake held through a sleep: the entry still wins at its edge
		wake = 1'b1;
		run(c, n);
		chk(sleep_mode, 1'b1);
		@(negedge sys_clk);
		wake = 1'b0;
		chk(sleep_mode, 1'b0);
		// the idle code only pads to its fixed length
		c = mk(OP_NONE);
		run(c, n);
		chk(n, 32'h03);
		chk(sleep_mode, 1'b0);
	endtask

	// ccr load with post-increment, then store with pre-decrement
	task automatic t_ldc_stc();
		scbm_cmd_t c;
		int n;
		c = mk(OP_LDC_INC);
		setw(10'h100, 16'h5A00);
		run(c, n);
		chk(n, 32'h09);
		chk(res.condition_code_register, 8'h5A);
		chk(res.ptr, 32'h102);
		c = mk(OP_STC_DEC);
		c.ptr = 32'h00000110;
		run(c, n);
		chk(n, 32'h09);
		chk(getw(10'h10E), 16'hA500);
		chk(res.ptr, 32'h10E);
		chk(res.condition_code_register, 8'hA5);
	endtask

	// block copies: zero counts, byte count ignores the high byte,
	// word count longer than the fifo
	task automatic t_blk();
		scbm_cmd_t c;
		int n;
		for (int i = 0; i < 16; i++)
		begin
			i_scbm_mem_model.mem[10'h300 + 10'(i)] = 8'h10 + 8'(i);
			i_scbm_mem_model.mem[10'h340 + 10'(i)] = 8'h00;
		end
		c = mk(OP_BLK_B);
		c.cnt = 16'h0300;
		run(c, n);
		chk(n, 32'h09);
		chk(res.cnt, 16'h0300);
		chk(res.src, 16'h0300);
		chk(i_scbm_mem_model.mem[10'h340], 8'h00);
		c.cnt = 16'h0103;
		run(c, n);
		chk(n, 32'h15);
		chk(res.cnt, 16'h0100);
		chk(res.src, 16'h0303);
		chk(res.dst, 16'h0343);
		for (int i = 0; i < 4; i++)
			chk(getb(10'h340 + 10'(i)), i < 3 ? 8'h10 + 8'(i) : 8'h00);
		c = mk(OP_BLK_W);
		run(c, n);
		chk(n, 32'h09);
		c.cnt = 16'h000A;
		run(c, n);
		chk(n, 32'h31);
		chk(res.cnt, 16'h0000);
		chk(res.dst, 16'h034A);
		for (int i = 0; i < 11; i++)
			chk(getb(10'h340 + 10'(i)), i < 10 ? 8'h10 + 8'(i) : 8'h00);
	endtask

	// slow memory lengthens execution, results unchanged
	task automatic t_wait();
		scbm_cmd_t c;
		int n;
		// short waits hide in the padding, so wait past the slack
		waits = 4'h8;
		c = mk(OP_LDC_INC);
		setw(10'h100, 16'h6600);
		run(c, n);
		chk(32'(n > 9), 32'h1);
		chk(res.condition_code_register, 8'h66);
		chk(res.ptr, 32'h102);
		waits = 4'h0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (6) @(negedge sys_clk);
		resetn = 1'b1;
		@(negedge sys_clk);
		t_trap();
		t_rte();
		t_sleep();
		t_ldc_stc();
		t_blk();
		t_wait();
		complete_run();
	end

	// hang guard
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		failures++;
		complete_run();
	end
endmodule
